// *** logic/scc_top.sv ***
// clock controller: source, divider, oscillator gating, gpio bus routing,
// audio master clock divider and seven system interrupt sources
// assumes: apb master on clock domain, oscillator events as sync pulses
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.svh"
module scc_top (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // platform status
   input  wire logic        hib_present,
   input  wire logic        hib_enabled,
   input  wire logic        deep_sleep,
   input  wire logic [31:0] flash_bytes,
   input  wire logic [6:0]  irq_event,
   input  wire logic        mclk_in,
   // clock outputs
   output logic [2:0]       osc_select,
   output logic             source_from_multiplier,
   output logic [5:0]       sys_div_m1,
   output logic [4:0]       xtal_code,
   output logic             sys_clock_en,
   output logic             internal_osc_disable,
   output logic             main_osc_disable,
   output logic             periph_gate_en,
   output logic [5:0]       gpio_ahb_sel,
   output logic             mclk_out,
   output logic             irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [5:0]       div;
      logic             usepll;
      logic [4:0]       xtal;
      scc_pkg::scc_osc_t osc;       // active source
      scc_pkg::scc_osc_t osc_req;   // requested source
      logic             pll_req;
      scc_pkg::scc_sw_t sw;
      logic [1:0]       gap;
      logic             ios_dis;
      logic             mos_dis;
      logic [5:0]       ahb;
      logic [7:0]       mdiv;
      logic [7:0]       mcnt;
      logic             mclk;
      logic [6:0]       ris;
      logic [6:0]       imc;
      logic             gate;
      logic [31:0]      rdata;
   } scc_state_t;
   scc_state_t s_q;
   scc_state_t s_d;

   // decode of a write to one offset, used for every writable register
   function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] o,
                                   input logic en);
      wr_hit = en && (a == o);
   endfunction : wr_hit

   logic        acc;
   logic        wr;
   logic        mapped;
   logic        m_on;
   logic [2:0]  req_osc;
   logic [4:0]  req_xt;
   logic        req_pll;
   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign m_on    = (s_q.mdiv != `SCC_MCLKDIV_RST);
   assign req_osc = pwdata[`SCC_CFG_OSC_LSB +: 3];
   assign req_xt  = pwdata[`SCC_CFG_XTAL_LSB +: 5];
   assign req_pll = pwdata[`SCC_CFG_USEPLL];
   assign mapped  = (paddr[11:6] == 6'h00) && (paddr[5:0] <= `SCC_OFS_STATUS)
                    && (paddr[1:0] == 2'h0);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (wr_hit(paddr, `SCC_OFS_CLKCFG, wr)) begin
         // (R1) divide ratio 1..64
         s_d.div = pwdata[`SCC_CFG_DIV_LSB +: 6];
         // (R3) crystal legal range with multiplier
         if (req_xt <= `SCC_XTAL_MAX && !(req_pll && req_xt < `SCC_XTAL_MIN_PLL)) begin
            s_d.xtal    = req_xt;
            s_d.pll_req = req_pll;
         end
         // (R4) (R5) five sources, ext low gated by hibernation
         if (req_osc <= 3'h4 && (req_osc != 3'h3 || (hib_present && hib_enabled)))
            s_d.osc_req = scc_pkg::scc_osc_t'(req_osc);
      end
      // (R6) (R7) separate disables, active source protected
      if (wr_hit(paddr, `SCC_OFS_OSCCTL, wr)) begin
         s_d.ios_dis = pwdata[0];
         s_d.mos_dis = pwdata[1];
      end
      // (R12) ahb routing on eligible ports only
      if (wr_hit(paddr, `SCC_OFS_GPIOAHB, wr))
         s_d.ahb = pwdata[5:0] & `SCC_GPIO_ELIG;
      // (R14) (R15) audio divider, zero switches it off
      if (wr_hit(paddr, `SCC_OFS_MCLKDIV, wr)) begin
         s_d.mdiv = pwdata[7:0];
         s_d.mcnt = 8'h00;
      end
      if (wr_hit(paddr, `SCC_OFS_IMC, wr))
         s_d.imc = pwdata[6:0];
      // (R10) gating select for deep sleep
      if (wr_hit(paddr, `SCC_OFS_SLPCTL, wr))
         s_d.gate = pwdata[0];
      // (R16) (R20) (R9) sticky, write one clears, set wins
      if (wr_hit(paddr, `SCC_OFS_RIS, wr))
         s_d.ris = s_q.ris & ~pwdata[6:0];
      s_d.ris = s_d.ris | irq_event;
      // (R21) glitch-free switch: stop, gap, restart
      case (s_q.sw)
         scc_pkg::SCC_SW_RUN: begin
            if (s_q.osc_req != s_q.osc || s_q.pll_req != s_q.usepll) begin
               s_d.sw  = scc_pkg::SCC_SW_OFF;
               s_d.gap = `SCC_SW_GAP;
            end
         end
         scc_pkg::SCC_SW_OFF: begin
            s_d.gap = s_q.gap - 2'h1;
            if (s_q.gap == 2'h1) begin
               // (R2) exactly one of multiplier or oscillator
               s_d.osc    = s_q.osc_req;
               s_d.usepll = s_q.pll_req;
               s_d.sw     = scc_pkg::SCC_SW_ON;
            end
         end
         scc_pkg::SCC_SW_ON: s_d.sw = scc_pkg::SCC_SW_RUN;
         default: s_d.sw = scc_pkg::SCC_SW_RUN;
      endcase
      // (R7) protect the source clocking after this edge
      if (s_d.osc == scc_pkg::SCC_OSC_INT || s_d.osc == scc_pkg::SCC_OSC_INT4)
         s_d.ios_dis = 1'b0;
      if (s_d.osc == scc_pkg::SCC_OSC_MAIN)
         s_d.mos_dis = 1'b0;
      // audio divider count
      if (m_on && mclk_in) begin
         if (s_q.mcnt >= s_q.mdiv) begin
            s_d.mcnt = 8'h00;
            s_d.mclk = ~s_q.mclk;
         end else begin
            s_d.mcnt = s_q.mcnt + 8'h01;
         end
      end
      if (!m_on)
         s_d.mclk = 1'b0;
      // read mux
      case (paddr)
         `SCC_OFS_CLKCFG:  s_d.rdata = {13'h0, s_q.osc_req, 3'h0, s_q.xtal, 1'b0,
                                        s_q.pll_req, s_q.div};
         `SCC_OFS_OSCCTL:  s_d.rdata = {30'h0, s_q.mos_dis, s_q.ios_dis};
         `SCC_OFS_GPIOAHB: s_d.rdata = {26'h0, gpio_ahb_sel};
         `SCC_OFS_MCLKDIV: s_d.rdata = {24'h0, s_q.mdiv};
         `SCC_OFS_RIS:     s_d.rdata = {25'h0, s_q.ris};
         `SCC_OFS_IMC:     s_d.rdata = {25'h0, s_q.imc};
         // (R19) masked view
         `SCC_OFS_MIS:     s_d.rdata = {25'h0, s_q.ris & s_q.imc};
         // (R11) flash size
         `SCC_OFS_FLASH:   s_d.rdata = flash_bytes;
         `SCC_OFS_SLPCTL:  s_d.rdata = {31'h0, s_q.gate};
         `SCC_OFS_STATUS:  s_d.rdata = {22'h0, s_q.sw, 1'b0, s_q.osc, 3'h0,
                                        s_q.usepll};
         default:          s_d.rdata = 32'h0000_0000;
      endcase
      if (rst) begin
         s_d = '0;
         s_d.osc     = scc_pkg::SCC_OSC_INT;
         s_d.osc_req = scc_pkg::SCC_OSC_INT;
      end
   end

   // state register
   always_ff @(posedge clock) begin
      s_q <= s_d;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // apb answers in the access cycle, one setup before
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata  = s_q.rdata;
   assign osc_select             = s_q.osc;
   assign source_from_multiplier = s_q.usepll;
   assign sys_div_m1             = s_q.div;
   assign xtal_code              = s_q.xtal;
   assign sys_clock_en           = (s_q.sw == scc_pkg::SCC_SW_RUN);
   assign internal_osc_disable   = s_q.ios_dis;
   assign main_osc_disable       = s_q.mos_dis;
   // (R10) gate peripherals only in deep sleep with gating on
   assign periph_gate_en = deep_sleep && s_q.gate;
   // (R13) audio clock off reverts ports to apb
   assign gpio_ahb_sel = m_on ? s_q.ahb : 6'h00;
   assign mclk_out     = s_q.mclk;
   // (R18) masked sources drive the line
   assign irq = |(s_q.ris & s_q.imc);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_sticky_set: assert property (@(posedge clock) disable iff (rst) // (R16)
      irq_event[0] |=> s_q.ris[0]) else $error("event not latched");
   a_w1c_clear: assert property (@(posedge clock) disable iff (rst) // (R20)
      (wr && paddr == `SCC_OFS_RIS && pwdata[1] && !irq_event[1]) |=> !s_q.ris[1])
      else $error("clear failed");
   a_irq_mask: assert property (@(posedge clock) disable iff (rst) // (R18)
      (s_q.imc == 7'h00) |-> !irq) else $error("masked irq seen");
   a_active_kept: assert property (@(posedge clock) disable iff (rst) // (R7)
      (s_q.osc == scc_pkg::SCC_OSC_MAIN) |-> !main_osc_disable)
      else $error("active oscillator off");
   a_int_kept: assert property (@(posedge clock) disable iff (rst) // (R7)
      (s_q.osc == scc_pkg::SCC_OSC_INT || s_q.osc == scc_pkg::SCC_OSC_INT4) |->
      !internal_osc_disable) else $error("active internal oscillator off");
   a_switch_gap: assert property (@(posedge clock) disable iff (rst) // (R21)
      (s_q.sw == scc_pkg::SCC_SW_RUN && $changed(s_q.osc_req)) |=> !sys_clock_en [*2])
      else $error("no gap on switch");
   a_ahb_revert: assert property (@(posedge clock) disable iff (rst) // (R13)
      (s_q.mdiv == 8'h00) |-> (gpio_ahb_sel == 6'h00)) else $error("ahb while mclk off");
   a_mclk_off: assert property (@(posedge clock) disable iff (rst) // (R15)
      $past(s_q.mdiv == 8'h00) && s_q.mdiv == 8'h00 |-> !mclk_out)
      else $error("mclk toggles");
   a_masked_read: assert property (@(posedge clock) disable iff (rst) // (R19)
      (acc && !pwrite && paddr == `SCC_OFS_MIS) |->
      (prdata[6:0] == $past(s_q.ris & s_q.imc))) else $error("bad masked read");
   c_switch: cover property (@(posedge clock) s_q.sw == scc_pkg::SCC_SW_ON);
   c_irq: cover property (@(posedge clock) irq);
   c_mclk: cover property (@(posedge clock) mclk_out);
endmodule : scc_top
`default_nettype wire

// *** logic/scc_map.svh ***
// register offsets, field positions and reset values of the clock controller
// assumes: included by the design file and the testbench, apb byte addresses, word aligned
// Summary of operation
// (R1) system divider picks one integer ratio from 1 to 64
// (R2) one bit picks multiplier output or oscillator directly
// (R3) crystal code from fixed set; codes below 3.57 MHz refused with multiplier
// (R4) five exclusive oscillator sources: main, internal, internal/4, ext low, int low
// (R5) external low source only selectable with hibernation present and enabled
// (R6) separate disable bits for internal and main oscillator
// (R7) disabling the oscillator currently clocking the device is ignored
// (R8) software enables external oscillator before selecting it
// (R9) multiplier lock sets the lock interrupt status bit
// (R10) deep-sleep with gating keeps only marked peripherals clocked, else all
// (R11) read-only flash size in bytes
// (R12) per-port select routes eligible gpio ports over ahb instead of apb
// (R13) audio master clock disabled forces gpio ports back to apb
// (R14) audio master clock made by programmable divider of input clock
// (R15) audio master clock output can be switched off entirely
// (R16) seven sticky interrupt sources held until software clears them
// (R17) software clears sources early since clear takes cycles
// (R18) per-source enable mask gates sources onto the interrupt line
// (R19) software reads raw or masked interrupt status
// (R20) status bits cleared by writing one; zero leaves them
// (R21) source switch without glitched or truncated clock pulses
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_OFS_CLKCFG   12'h000
`define SCC_OFS_OSCCTL   12'h004
`define SCC_OFS_GPIOAHB  12'h008
`define SCC_OFS_MCLKDIV  12'h00c
`define SCC_OFS_RIS      12'h010
`define SCC_OFS_IMC      12'h014
`define SCC_OFS_MIS      12'h018
`define SCC_OFS_FLASH    12'h01c
`define SCC_OFS_SLPCTL   12'h020
`define SCC_OFS_STATUS   12'h024
// clock config fields
`define SCC_CFG_DIV_LSB  0
`define SCC_CFG_USEPLL   6
`define SCC_CFG_XTAL_LSB 8
`define SCC_CFG_OSC_LSB  16
`define SCC_CFG_RESET    32'h0000_0000
`define SCC_XTAL_MIN_PLL 5'h04
`define SCC_XTAL_MAX     5'h16
`define SCC_IRQ_N        7
`define SCC_GPIO_ELIG    6'h33
`define SCC_MCLKDIV_RST  8'h00
// glitch-free switch: cycles off before new source comes on
`define SCC_SW_GAP       2'h2
`endif

// *** logic/scc_pkg.sv ***
// types of the clock controller
// assumes: scc_map.svh for numbers
package scc_pkg;
   typedef enum logic [2:0] {
      SCC_OSC_MAIN = 3'h0, SCC_OSC_INT = 3'h1, SCC_OSC_INT4 = 3'h2,
      SCC_OSC_EXTLF = 3'h3, SCC_OSC_INTLF = 3'h4
   } scc_osc_t;
   typedef enum logic [1:0] {
      SCC_SW_RUN = 2'h0, SCC_SW_OFF = 2'h1, SCC_SW_ON = 2'h2
   } scc_sw_t;
endpackage : scc_pkg

// *** test/tb_system_clock_and_sysctl_irq.sv ***
// testbench for the clock controller: table of clock settings, then hand tests
// assumes: scc_top with apb slave, pready high, offsets from scc_map.svh
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.svh"
module tb_system_clock_and_sysctl_irq;
   typedef struct {logic [31:0] w; logic [31:0] e;} scc_tb_row_t;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, hib_present, hib_enabled;
   logic deep_sleep, mclk_in, source_from_multiplier, sys_clock_en, irq, mclk_out;
   logic internal_osc_disable, main_osc_disable, periph_gate_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, flash_bytes, rd;
   logic [6:0]  irq_event;
   logic [2:0]  osc_select;
   logic [5:0]  sys_div_m1, gpio_ahb_sel;
   logic [4:0]  xtal_code;
   scc_tb_row_t rows [8];
   int n_errors = 0, check_count = 0, lows, tog, i;
   logic [31:0] prev;
   scc_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .hib_present(hib_present), .hib_enabled(hib_enabled), .deep_sleep(deep_sleep),
      .flash_bytes(flash_bytes), .irq_event(irq_event), .mclk_in(mclk_in),
      .osc_select(osc_select), .source_from_multiplier(source_from_multiplier),
      .sys_div_m1(sys_div_m1), .xtal_code(xtal_code), .sys_clock_en(sys_clock_en),
      .internal_osc_disable(internal_osc_disable), .main_osc_disable(main_osc_disable),
      .periph_gate_en(periph_gate_en), .gpio_ahb_sel(gpio_ahb_sel), .mclk_out(mclk_out),
      .irq(irq));
   // ------------------------------
   // clock, helpers and bus tasks
   // ------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   function automatic logic [31:0] cfg(logic [5:0] d, logic p, logic [4:0] x, logic [2:0] o);
      return {13'h0, o, 3'h0, x, 1'b0, p, d};
   endfunction : cfg
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // setup cycle, access until pready, release after the sampling edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         complete_run();
      end else begin
         rd = prdata;
         chk("pslverr", {31'h0, a >= 12'h028}, {31'h0, pslverr});
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clock);
      end
   endtask : apb
   task automatic step(int n);
      repeat (n) @(posedge clock);
   endtask : step
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; hib_present = 1'b0; hib_enabled = 1'b0; deep_sleep = 1'b0;
      flash_bytes = 32'h0004_0000; irq_event = 7'h00; mclk_in = 1'b0;
      rows[0] = '{cfg(6'h3f, 0, 5'h10, 1), cfg(6'h3f, 0, 5'h10, 1)};
      rows[1] = '{cfg(6'h05, 1, 5'h04, 0), cfg(6'h05, 1, 5'h04, 0)};
      rows[2] = '{cfg(6'h05, 1, 5'h03, 0), cfg(6'h05, 1, 5'h04, 0)};
      rows[3] = '{cfg(6'h05, 1, 5'h17, 0), cfg(6'h05, 1, 5'h04, 0)};
      rows[4] = '{cfg(6'h05, 0, 5'h02, 0), cfg(6'h05, 0, 5'h02, 0)};
      rows[5] = '{cfg(6'h05, 0, 5'h02, 3), cfg(6'h05, 0, 5'h02, 0)};
      rows[6] = '{cfg(6'h00, 0, 5'h02, 4), cfg(6'h00, 0, 5'h02, 4)};
      rows[7] = '{cfg(6'h00, 0, 5'h02, 2), cfg(6'h00, 0, 5'h02, 2)};
      step(4);
      rst <= 1'b0;
      step(1);
      chk("osc_select", 32'h1, {29'h0, osc_select});
      chk("sys_clock_en", 32'h1, {31'h0, sys_clock_en});
      prev = cfg(6'h00, 0, 5'h00, 1);
      // table of clock settings, switch gap counted after each write
      for (i = 0; i < 8; i++) begin
         apb(1'b1, `SCC_OFS_CLKCFG, rows[i].w);
         lows = 0;
         repeat (8) begin
            @(posedge clock);
            if (sys_clock_en !== 1'b1) lows++;
         end
         chk("switch_gap", ({prev[18:16], prev[6]} != {rows[i].e[18:16], rows[i].e[6]}) ? 3 : 0,
             lows);
         chk("sys_div_m1", {26'h0, rows[i].e[5:0]}, {26'h0, sys_div_m1});
         chk("use_pll", {31'h0, rows[i].e[6]}, {31'h0, source_from_multiplier});
         chk("xtal_code", {27'h0, rows[i].e[12:8]}, {27'h0, xtal_code});
         chk("osc_select", {29'h0, rows[i].e[18:16]}, {29'h0, osc_select});
         prev = rows[i].e;
      end
      // disabling the active main oscillator is ignored, the other is not
      apb(1'b1, `SCC_OFS_CLKCFG, cfg(6'h00, 0, 5'h02, 0));
      step(8);
      apb(1'b1, `SCC_OFS_OSCCTL, 32'h3);
      step(1);
      chk("main_dis", 32'h0, {31'h0, main_osc_disable});
      chk("int_dis", 32'h1, {31'h0, internal_osc_disable});
      // hibernation present and enabled before the external low source is selected
      hib_present <= 1'b1; hib_enabled <= 1'b1;
      apb(1'b1, `SCC_OFS_CLKCFG, cfg(6'h00, 0, 5'h02, 3));
      step(8);
      chk("osc_extlf", 32'h3, {29'h0, osc_select});
      // gpio routing follows the audio clock enable
      apb(1'b1, `SCC_OFS_GPIOAHB, 32'h3f);
      step(1);
      chk("gpio_off", 32'h0, {26'h0, gpio_ahb_sel});
      apb(1'b1, `SCC_OFS_MCLKDIV, 32'h1);
      mclk_in <= 1'b1;
      step(2);
      chk("gpio_on", 32'h33, {26'h0, gpio_ahb_sel});
      tog = 0;
      prev[0] = mclk_out;
      repeat (8) begin
         @(posedge clock);
         if (mclk_out !== prev[0]) tog++;
         prev[0] = mclk_out;
      end
      chk("mclk_toggles", 32'd4, tog);
      apb(1'b1, `SCC_OFS_MCLKDIV, 32'h0);
      step(2);
      prev[0] = mclk_out;
      step(8);
      chk("mclk_stopped", {31'h0, prev[0]}, {31'h0, mclk_out});
      chk("gpio_back", 32'h0, {26'h0, gpio_ahb_sel});
      // flash size and deep-sleep gating
      apb(1'b0, `SCC_OFS_FLASH, 32'h0);
      chk("flash", 32'h0004_0000, rd);
      apb(1'b1, `SCC_OFS_SLPCTL, 32'h1);
      deep_sleep <= 1'b1;
      step(2);
      chk("gate_on", 32'h1, {31'h0, periph_gate_en});
      deep_sleep <= 1'b0;
      step(2);
      chk("gate_off", 32'h0, {31'h0, periph_gate_en});
      // sticky sources, mask, raw and masked reads, write one to clear
      irq_event <= 7'h7f;
      step(1);
      irq_event <= 7'h00;
      step(2);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, `SCC_OFS_IMC, 32'h05);
      step(1);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b0, `SCC_OFS_MIS, 32'h0);
      chk("mis", 32'h05, rd);
      apb(1'b1, `SCC_OFS_RIS, 32'h01);
      apb(1'b1, `SCC_OFS_RIS, 32'h00);
      apb(1'b0, `SCC_OFS_RIS, 32'h0);
      chk("ris", 32'h7e, rd);
      apb(1'b1, `SCC_OFS_RIS, 32'h7f);
      step(1);
      chk("irq_clear", 32'h0, {31'h0, irq});
      // lock event alone sets only the lock bit
      irq_event <= 7'h01;
      step(1);
      irq_event <= 7'h00;
      apb(1'b0, `SCC_OFS_RIS, 32'h0);
      chk("lock_ris", 32'h01, rd);
      apb(1'b0, 12'h100, 32'h0);
      complete_run();
   end
endmodule : tb_system_clock_and_sysctl_irq
`default_nettype wire
